// ===== inc/eeprom_pec_pkg.sv
// Purpose: Constants and types for the EEPROM program and erase control block.
// Assumes: One 512-byte array at 0x0800 behind an 8-bit register port.
// Notes:   Rules carried by the block follow, one to a line.
// Operation
// (R01) Reset and each read of the nonvolatile byte copy it into the volatile config.
// (R02) Nonvolatile byte is programmed and erased like an array byte, used after reload.
// (R03) Armed security blocks program and erase of 0x08F0 through 0x08FF.
// (R04) Armed security refuses block erase and bulk erase.
// (R05) Armed security refuses program and erase of the nonvolatile byte.
// (R06) Armed security still allows byte erase and programming of 0x0800 to 0x08EF.
// (R07) Armed security leaves secured locations readable.
// (R08) Armed security makes writes to secured addresses non-qualifying and unlatched.
// (R09) Armed security is permanent and freezes every nonvolatile field.
// (R10) Pump clock select: one routes bus clock, zero the RC oscillator; reset clears.
// (R11) Software should pick the RC oscillator below an 8 MHz bus.
// (R12) Power-down disables the array, reads undefined; reset clears it.
// (R13) Software waits a recovery time after clearing power-down.
// (R14) Mode bits select program, byte, block or bulk erase; protection suppresses.
// (R15) Latch bit captures address and data, stays set while high voltage is on.
// (R16) High voltage turns on only with latch set and a qualifying write seen.
// (R17) Clearing latch and high voltage together clears only high voltage.
// (R18) Config byte: redundancy, two config bits, security, four protect bits; erased ones.
// (R19) Security bit zero protects a 16-byte region, one leaves it open.
// (R20) Each protect bit set guards its block; reset copies them.
// (R21) Two config bits are readable and writable, loaded at reset.
// (R22) Software keeps the redundancy bit at zero.
// (R23) Four 128-byte blocks, protect bit n guards block n from 0x0800 up.
// (R24) Each new qualifying write replaces the latch; array reads return latched data.
// (R25) Control register field placement is chosen here.
package eeprom_pec_pkg;
  localparam int         ARR_SIZE    = 512;
  localparam logic [15:0] ARR_BASE   = 16'h0800;
  localparam logic [15:0] ARR_LAST   = 16'h09FF;
  localparam logic [15:0] SEC_LO     = 16'h08F0;
  localparam logic [15:0] SEC_HI     = 16'h08FF;
  localparam logic [15:0] NV_ADDR    = 16'hFE1C;
  localparam logic [15:0] CTRL_ADDR  = 16'hFE1D;
  localparam logic [15:0] VCFG_ADDR  = 16'hFE1F;
  // Control register fields.
  localparam int CTL_PCLK = 7;
  localparam int CTL_PDN  = 5;
  localparam int CTL_MHI  = 4;
  localparam int CTL_MLO  = 3;
  localparam int CTL_LAT  = 1;
  localparam int CTL_HV   = 0;
  localparam logic [7:0] CTL_WMASK = 8'hBB; // R25
  // Configuration byte fields.
  localparam int CFG_SEC = 4;
  localparam logic [7:0] CFG_WMASK = 8'h6F;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] VCFG_RST  = 8'hFF;
  localparam logic [7:0] ERASED    = 8'hFF;
  localparam logic [7:0] OFF_RD    = 8'hFF;
  localparam logic [7:0] UNMAP_RD  = 8'h00;
  // Idle cycles software leaves after clearing power-down; the block does not enforce it.
  localparam int         OFF_RECOVERY = 4;
  typedef enum logic [1:0] {
    MODE_PROG, MODE_BYTE_ERASE, MODE_BLOCK_ERASE, MODE_BULK_ERASE
  } op_mode_t;
  typedef struct packed {
    logic       boot;
    logic [7:0] ctrl;
    logic [8:0] laddr;
    logic       lnv;
    logic [7:0] ldata;
    logic       lval;
    logic [7:0] vcfg;
    logic [7:0] rdata;
    logic       hv_apply;
  } pec_state_t;
endpackage

// ===== verilog/eeprom_program_erase_control.sv
// Purpose: Program, erase and protection control of a 512-byte EEPROM array.
// Assumes: Bus inputs synchronous to mclk; por_n marks power-on of the cells.
// Notes:   The pump analog timing is not modelled; the cell update happens when
//          high voltage is switched off after having been applied.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module eeprom_program_erase_control (
  input  wire logic        mclk,        // Bus clock.
  input  wire logic        resetn,      // System reset, active low.
  input  wire logic        por_n,       // Power-on of cell storage, active low.
  input  wire logic [15:0] addr,        // Bus address.
  input  wire logic [7:0]  wdata,       // Bus write data.
  input  wire logic        we,          // Write strobe.
  input  wire logic        re,          // Read strobe.
  output logic      [7:0]  rdata,       // Read data, cycle after re.
  output logic             pump_on,     // Program or erase voltage applied.
  output logic             pump_clk_bus,// Pump clock from bus clock when high.
  output logic             array_off,   // Array powered down.
  output logic             sec_armed,   // Security option in force.
  output logic      [1:0]  mcu_config   // General-purpose config bits.
);
  import eeprom_pec_pkg::*;

  pec_state_t s;
  pec_state_t n;
  logic [7:0] mem [ARR_SIZE];
  logic [7:0] mem_nxt [ARR_SIZE];
  logic [7:0] nv_r;
  logic       armed;
  logic       in_arr;
  logic       sec_a;
  logic       sec_l;
  logic       qual;
  logic       ok;
  logic       op_go;
  logic [1:0] blk;
  op_mode_t   mode;
  logic [7:0] w;
  logic       lat_new;
  logic       hv_new;

  assign armed  = ~s.vcfg[CFG_SEC];                            // R19
  assign in_arr = (addr >= ARR_BASE) && (addr <= ARR_LAST);
  assign sec_a  = (addr >= SEC_LO) && (addr <= SEC_HI);
  assign sec_l  = ({7'h00, s.laddr} >= 16'(SEC_LO - ARR_BASE)) &&
                  ({7'h00, s.laddr} <= 16'(SEC_HI - ARR_BASE));
  assign blk    = s.laddr[8:7];                                // R23
  assign mode   = op_mode_t'({s.ctrl[CTL_MHI], s.ctrl[CTL_MLO]});

  // Whether the latched operation may apply voltage.
  always_comb begin
    if (s.lnv) begin
      ok = !armed && (mode == MODE_PROG || mode == MODE_BYTE_ERASE); // R05 R02
    end else begin
      case (mode)
        MODE_PROG, MODE_BYTE_ERASE: ok = !s.vcfg[blk] && !(armed && sec_l); // R03 R06 R20
        MODE_BLOCK_ERASE:           ok = !armed && !s.vcfg[blk];             // R04 R14
        MODE_BULK_ERASE:            ok = !armed && (s.vcfg[3:0] == 4'h0);    // R04 R14
        default:                    ok = 1'b0;
      endcase
    end
  end

  // A qualifying write is locked out while voltage is on so the target
  // cannot move under an operation in progress.
  assign qual = we && s.ctrl[CTL_LAT] && !s.ctrl[CTL_HV] && !s.ctrl[CTL_PDN] &&
                ((in_arr && !(armed && sec_a)) ||                   // R08
                 ((addr == NV_ADDR) && !armed));                    // R05

  always_comb begin
    n       = s;
    w       = wdata;
    lat_new = s.ctrl[CTL_LAT];
    hv_new  = s.ctrl[CTL_HV];
    n.boot  = 1'b0;
    if (s.boot || (re && addr == NV_ADDR)) begin
      n.vcfg = nv_r;                                                // R01 R02
    end
    if (qual) begin
      n.laddr = addr[8:0];                                          // R24
      n.lnv   = (addr == NV_ADDR);
      n.ldata = wdata;
      n.lval  = 1'b1;                                               // R16
    end
    // With latch set, control writes wait for a qualifying write first.
    if (we && addr == CTRL_ADDR && !(s.ctrl[CTL_LAT] && !s.lval)) begin
      n.ctrl[CTL_PCLK] = w[CTL_PCLK];                               // R10
      n.ctrl[CTL_PDN]  = w[CTL_PDN];                                // R12
      if (!s.ctrl[CTL_HV]) begin
        n.ctrl[CTL_MHI] = w[CTL_MHI];                               // R14
        n.ctrl[CTL_MLO] = w[CTL_MLO];
      end
      hv_new  = w[CTL_HV] && s.ctrl[CTL_LAT] && s.lval;             // R16
      // A write that sets high voltage keeps the latch set, whatever its latch bit says.
      lat_new = w[CTL_LAT] || s.ctrl[CTL_HV] || hv_new;             // R15 R17
      n.ctrl[CTL_HV]  = hv_new;
      n.ctrl[CTL_LAT] = lat_new;
      if (!lat_new) begin
        n.lval = 1'b0;
      end
    end
    if (we && addr == VCFG_ADDR && !armed) begin
      n.vcfg = (s.vcfg & ~CFG_WMASK) | (wdata & CFG_WMASK);         // R21 R09
    end
    n.hv_apply = n.ctrl[CTL_HV] && ok;                              // R16 R20
    op_go      = s.ctrl[CTL_HV] && !n.ctrl[CTL_HV] && ok;
    n.rdata    = UNMAP_RD;
    if (re) begin
      if (in_arr) begin
        if (s.ctrl[CTL_PDN]) begin
          n.rdata = OFF_RD;                                         // R12
        end else if (s.ctrl[CTL_LAT] && s.lval) begin
          n.rdata = s.ldata;                                        // R24
        end else begin
          n.rdata = mem[addr[8:0]];                                 // R07
        end
      end else if (addr == NV_ADDR) begin
        n.rdata = nv_r;
      end else if (addr == CTRL_ADDR) begin
        n.rdata = s.ctrl & CTL_WMASK;
      end else if (addr == VCFG_ADDR) begin
        n.rdata = s.vcfg;                                           // R18
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s.boot     <= 1'b1;
      s.ctrl     <= CTRL_RST;                                       // R10 R12 R14 R15 R16
      s.laddr    <= 9'h000;
      s.lnv      <= 1'b0;
      s.ldata    <= 8'h00;
      s.lval     <= 1'b0;
      s.vcfg     <= VCFG_RST;
      s.rdata    <= 8'h00;
      s.hv_apply <= 1'b0;
    end else begin
      s <= n;
    end
  end

  // Each cell decodes its own update, so one operation touches a byte, a block or all.
  for (genvar g = 0; g < ARR_SIZE; g++) begin : g_cell
    localparam logic [8:0] CELL = 9'(g);
    logic cell_hit;
    assign cell_hit   = (mode == MODE_BULK_ERASE) ||                             // R14
                        ((mode == MODE_BLOCK_ERASE) && (CELL[8:7] == blk)) ||    // R23
                        (CELL == s.laddr);
    assign mem_nxt[g] = (op_go && !s.lnv && cell_hit) ?
                        ((mode == MODE_PROG) ? (mem[g] & s.ldata) : ERASED) :    // R14
                        mem[g];
  end

  // Cell storage survives system reset; only power-on returns it to erased.
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      mem  <= '{default: ERASED};
      nv_r <= ERASED;                                               // R18
    end else begin
      mem <= mem_nxt;
      if (op_go && s.lnv) begin
        nv_r <= (mode == MODE_PROG) ? (nv_r & s.ldata) : ERASED;    // R02
      end
    end
  end

  assign rdata        = s.rdata;
  assign pump_on      = s.hv_apply;
  assign pump_clk_bus = s.ctrl[CTL_PCLK];                           // R10
  assign array_off    = s.ctrl[CTL_PDN];
  assign sec_armed    = armed;
  assign mcu_config   = s.vcfg[6:5];
endmodule

// ===== testbench/pec_checker.sv
// Purpose: Port assertions for the EEPROM program and erase control.
// Assumes: One clock domain; sees only the top module ports.
// Notes:   Read data must be zero outside the answer cycle.
`timescale 1ns/1ps
module pec_checker
  import eeprom_pec_pkg::*;
(
  input wire logic        mclk,         // Clock.
  input wire logic        resetn,       // Reset, active low.
  input wire logic        por_n,        // Cell power-on.
  input wire logic [15:0] addr,         // Address.
  input wire logic [7:0]  wdata,        // Write data.
  input wire logic        we,           // Write strobe.
  input wire logic        re,           // Read strobe.
  input wire logic [7:0]  rdata,        // Read data.
  input wire logic        pump_on,      // Pump on.
  input wire logic        pump_clk_bus, // Pump clock.
  input wire logic        array_off,    // Power-down.
  input wire logic        sec_armed,    // Security.
  input wire logic [1:0]  mcu_config    // Config bits.
);
  wire ctl_w = we && addr == CTRL_ADDR;
  wire in_arr = addr >= ARR_BASE && addr <= ARR_LAST;
  wire mapped = in_arr || addr == NV_ADDR || addr == CTRL_ADDR || addr == VCFG_ADDR;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_idle_rdata: assert property (!re |=> rdata == 8'h00) else $error("rdata not zero");
  a_unmapped_read: assert property (re && !mapped |=> rdata == UNMAP_RD) else $error("unmapped read");
  a_off_read: assert property (re && array_off && in_arr |=> rdata == OFF_RD) else $error("off read");
  a_ctrl_hold: assert property (!ctl_w |=> $stable(pump_clk_bus) && $stable(array_off))
    else $error("control output moved");
  a_pump_drop: assert property (ctl_w && !wdata[CTL_HV] |-> ##[1:2] !pump_on) else $error("pump stays");
  a_reset_clear: assert property ($rose(resetn) |-> !pump_on && !pump_clk_bus && !array_off)
    else $error("reset values");
  a_sec_sticky: assert property (sec_armed |=> sec_armed) else $error("security dropped");
  a_sec_source: assert property ($rose(sec_armed) |-> $past(re && addr == NV_ADDR) || $past(!resetn, 2))
    else $error("security without load");
  a_cfg_source: assert property ($changed(mcu_config) |->
    $past(re && addr == NV_ADDR || we && addr == VCFG_ADDR) || $past(!resetn, 2)) else $error("config moved");
  c_pump: cover property (pump_on);
  c_armed: cover property (sec_armed);
  c_off_read: cover property (array_off && re);
endmodule
bind eeprom_program_erase_control pec_checker pec_checker_inst (.mclk(mclk), .resetn(resetn), .por_n(por_n),
  .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata), .pump_on(pump_on), .pump_clk_bus(pump_clk_bus),
  .array_off(array_off), .sec_armed(sec_armed), .mcu_config(mcu_config));

// ===== testbench/testbench.sv
// Purpose: Directed test of the EEPROM program and erase control.
// Assumes: Cells start erased after por_n; all traffic on the register port.
// Notes:   Cell 09FE is written first in every op latch; it stays erased only if the latch is replaced.
`timescale 1ns/1ps
module testbench;
  import eeprom_pec_pkg::*;
  logic        mclk = 1'b0, resetn = 1'b0, por_n = 1'b0, we = 1'b0, re = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, rdata;
  logic        pump_on, pump_clk_bus, array_off, sec_armed;
  logic [1:0]  mcu_config;
  int          mismatches = 0, tests_run = 0, cycles = 0;
  eeprom_program_erase_control eeprom_program_erase_control_inst (.mclk(mclk), .resetn(resetn), .por_n(por_n),
    .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata), .pump_on(pump_on), .pump_clk_bus(pump_clk_bus),
    .array_off(array_off), .sec_armed(sec_armed), .mcu_config(mcu_config));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d.", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    {addr, wdata, we} <= {a, d, 1'b1};
    @(posedge mclk);
    we <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    {addr, re} <= {a, 1'b1};
    @(posedge mclk);
    re <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge mclk);
  endtask
  // Packs pump, pump clock, power-down, security and config bits into one byte.
  task automatic flags(input logic [7:0] exp);
    @(posedge mclk);
    #1 chk({2'b00, pump_on, pump_clk_bus, array_off, sec_armed, mcu_config}, exp);
    @(posedge mclk);
  endtask
  task automatic op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d, input logic [7:0] fl);
    wr(CTRL_ADDR, {3'b000, m, 3'b010});
    wr(16'h09FE, 8'h00);
    wr(a, d);
    if (a != NV_ADDR) rd(ARR_BASE, d);
    wr(CTRL_ADDR, {3'b000, m, 3'b011});
    flags(fl);
    wr(CTRL_ADDR, 8'h00);
    rd(CTRL_ADDR, {3'b000, m, 3'b010});
    wr(CTRL_ADDR, 8'h00);
  endtask
  // A refused target leaves the latch waiting, so a plain cell write releases it.
  task automatic refuse(input logic [15:0] a);
    wr(CTRL_ADDR, 8'h02);
    wr(a, 8'h00);
    wr(CTRL_ADDR, 8'h03);
    rd(CTRL_ADDR, 8'h02);
    wr(16'h0805, 8'hFF);
    wr(CTRL_ADDR, 8'h00);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    {resetn, por_n} <= 2'b11;
    repeat (2) @(posedge mclk);
    rd(CTRL_ADDR, CTRL_RST);
    rd(VCFG_ADDR, VCFG_RST);
    rd(16'h1234, UNMAP_RD);
    wr(VCFG_ADDR, 8'h01);
    rd(VCFG_ADDR, 8'h91);
    op(2'b00, 16'h0810, 8'h00, 8'h00);
    op(2'b00, 16'h0890, 8'h5A, 8'h20);
    rd(16'h0890, 8'h5A);
    op(2'b00, NV_ADDR, 8'h60, 8'h20);
    flags(8'h00);
    rd(NV_ADDR, 8'h60);
    flags(8'h07);
    op(2'b11, 16'h0805, 8'h00, 8'h07);
    op(2'b10, 16'h0805, 8'h00, 8'h07);
    op(2'b01, 16'h0890, 8'h00, 8'h27);
    rd(16'h0890, ERASED);
    op(2'b00, 16'h0806, 8'h3C, 8'h27);
    refuse(16'h08F5);
    refuse(NV_ADDR);
    rd(16'h08F5, ERASED);
    rd(NV_ADDR, 8'h60);
    wr(VCFG_ADDR, 8'h0F);
    rd(VCFG_ADDR, 8'h60);
    wr(CTRL_ADDR, 8'hA0);
    rd(CTRL_ADDR, 8'hA0);
    flags(8'h1F);
    rd(16'h0806, OFF_RD);
    wr(CTRL_ADDR, 8'h00);
    repeat (OFF_RECOVERY) @(posedge mclk);
    rd(16'h0806, 8'h3C);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    flags(8'h07);
    rd(16'h09FE, ERASED);
    tally_and_finish();
  end
endmodule
